// File: rtl/host_pin_mux_params.svh
// Constants for the host pin multiplexer and report interrupt.
// Assumes a single 100 MHz core clock and registered pin pads.
//
// Behaviour
// - Interrupt pin low while any report waits.
// - No reports pending: interrupt pin released, pulled up.
// - Each read consumes one; release after last.
// - LIN mode: interrupt pin may enable transceiver.
// - Two-wire mode: pin A is data line.
// - Four-wire mode: pin A is clock input.
// - LIN mode: pin A is receive input.
// - Two-wire mode: pin B is clock line.
// - Four-wire mode: pin B is select, low.
// - LIN mode: pin B is transmit output.
// - Three pulled-up general purpose pins, host configured.
// - GP1 may be hsync, GP2 frame sync.
// - Master reset low acts asynchronously, resets all.
`ifndef HOST_PIN_MUX_PARAMS_SVH
`define HOST_PIN_MUX_PARAMS_SVH

// ---------------------------------------------------------------
// Pin positions in the synchronised input vector
// ---------------------------------------------------------------
`define PIN_A 0
`define PIN_B 1
`define PIN_C 2
`define PIN_D 3
`define PIN_GP0 4
`define PIN_NUM 7

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SYNC_RST_VAL 7'h7F
`define STRAP_SETTLE_CYC 3'h3
`define GP_HSYNC_IDX 1
`define GP_VSYNC_IDX 2

`endif

// File: rtl/host_pin_mux_pkg.sv
// Types shared by the host pin multiplexer.
// Assumes the core protocol engines attach through these structs.
package host_pin_mux_pkg;

  // ---------------------------------------------------------------
  // Communication modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TWO_WIRE,
    MODE_FOUR_WIRE,
    MODE_LIN,
    MODE_NONE
  } host_mode_e;

  // Receive-side signals handed to the protocol engines
  typedef struct packed {
    logic sda;
    logic scl;
    logic sck;
    logic sck_rise;
    logic sck_fall;
    logic ss_n;
    logic mosi;
    logic lin_rx;
  } host_rx_s;

  // Transmit-side requests from the protocol engines
  typedef struct packed {
    logic sda_low;
    logic miso;
    logic lin_tx;
    logic lin_transceiver_enable;
  } host_tx_s;

endpackage

// File: rtl/host_port_pin_mux_irq.sv
// Host pin function selection and report-pending interrupt.
// Assumes pads resolve in/out/oe; core supplies mode and requests.
`timescale 1ns/1ps
`default_nettype none
`include "host_pin_mux_params.svh"

module host_port_pin_mux_irq #(
  parameter int CNT_W = 4
) (
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_reset_n,
  // Mode and options from configuration
  input wire host_pin_mux_pkg::host_mode_e mode,
  input wire logic lin_en_sel,
  input wire logic hsync_sel,
  input wire logic vsync_sel,
  // Report queue events
  input wire logic report_push,
  input wire logic report_consumed,
  // Protocol engine side
  input wire host_pin_mux_pkg::host_tx_s tx,
  output host_pin_mux_pkg::host_rx_s rx,
  output logic [CNT_W-1:0] pending_count,
  output logic two_wire_address_strap,
  output logic two_wire_mode_strap_n,
  // General purpose pins, core side
  input wire logic [2:0] gp_out,
  input wire logic [2:0] gp_dir,
  output logic [2:0] gp_in,
  output logic hsync,
  output logic external_frame_sync,
  // Interrupt pin, open drain
  input wire logic report_pending_irq_n_in,
  output logic report_pending_irq_n_out,
  output logic report_pending_irq_n_oe,
  // Pin A
  input wire logic host_serial_data_line_in,
  output logic host_serial_data_line_out,
  output logic host_serial_data_line_oe,
  // Pin B
  input wire logic host_serial_clock_line_in,
  output logic host_serial_clock_line_out,
  output logic host_serial_clock_line_oe,
  // Pin C, address strap or data in
  input wire logic pin_c_in,
  output logic pin_c_out,
  output logic pin_c_oe,
  // Pin D, mode strap or data out
  input wire logic pin_d_in,
  output logic pin_d_out,
  output logic pin_d_oe,
  // General purpose pins
  input wire logic [2:0] gp_pin_in,
  output logic [2:0] gp_pin_out,
  output logic [2:0] gp_pin_oe
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [`PIN_NUM-1:0] pin_raw;
  logic [`PIN_NUM-1:0] sync1_ff;
  logic [`PIN_NUM-1:0] sync2_ff;
  logic sck_prev_ff;

  assign pin_raw = {gp_pin_in, pin_d_in, pin_c_in,
                    host_serial_clock_line_in, host_serial_data_line_in};

  // Two flops; first stage read only by second
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      sync1_ff <= `SYNC_RST_VAL;
      sync2_ff <= `SYNC_RST_VAL;
    end
    else if (sys_rst)
    begin
      sync1_ff <= `SYNC_RST_VAL;
      sync2_ff <= `SYNC_RST_VAL;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Previous host clock level for edge finding; resets high like the
  // pulled-up idle pin, so no false edge follows reset
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
      sck_prev_ff <= 1'b1;
    else if (sys_rst)
      sck_prev_ff <= 1'b1;
    else
      sck_prev_ff <= sync2_ff[`PIN_A];
  end

  // ---------------------------------------------------------------
  // Pending report counter
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic cnt_full;

  assign cnt_full = &cnt_ff;

  // Push and consume together cancel; neither is lost
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (report_push && !report_consumed && !cnt_full)
      nxt_cnt = cnt_ff + 1'b1;
    else if (report_consumed && !report_push && cnt_ff != '0)
      nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
      cnt_ff <= '0;
    else if (sys_rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign pending_count = cnt_ff;

  // ---------------------------------------------------------------
  // Interrupt / transceiver enable pin
  // ---------------------------------------------------------------
  logic irq_oe_ff;

  // Level output from next count so it tracks the counter exactly;
  // a level lets the host catch reports still queued.
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
      irq_oe_ff <= 1'b0;
    else if (sys_rst)
      irq_oe_ff <= 1'b0;
    else if (mode == host_pin_mux_pkg::MODE_LIN && lin_en_sel)
      irq_oe_ff <= !tx.lin_transceiver_enable;
    else
      irq_oe_ff <= (nxt_cnt != '0);
  end

  assign report_pending_irq_n_out = 1'b0;
  assign report_pending_irq_n_oe = irq_oe_ff;

  // ---------------------------------------------------------------
  // Shared pins A..D
  // ---------------------------------------------------------------
  logic a_oe_ff;
  logic b_out_ff;
  logic b_oe_ff;
  logic d_out_ff;
  logic d_oe_ff;

  // Output drive per mode; unknown mode releases every pin
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      a_oe_ff <= 1'b0;
      b_out_ff <= 1'b1;
      b_oe_ff <= 1'b0;
      d_out_ff <= 1'b0;
      d_oe_ff <= 1'b0;
    end
    else if (sys_rst)
    begin
      a_oe_ff <= 1'b0;
      b_out_ff <= 1'b1;
      b_oe_ff <= 1'b0;
      d_out_ff <= 1'b0;
      d_oe_ff <= 1'b0;
    end
    else
    begin
      a_oe_ff <= 1'b0;
      b_out_ff <= 1'b1;
      b_oe_ff <= 1'b0;
      d_out_ff <= 1'b0;
      d_oe_ff <= 1'b0;
      case (mode)
        host_pin_mux_pkg::MODE_TWO_WIRE:
        begin
          a_oe_ff <= tx.sda_low;
        end
        host_pin_mux_pkg::MODE_FOUR_WIRE:
        begin
          // Data out only while selected, so a shared bus stays free
          d_out_ff <= tx.miso;
          d_oe_ff <= !sync2_ff[`PIN_B];
        end
        host_pin_mux_pkg::MODE_LIN:
        begin
          b_out_ff <= tx.lin_tx;
          b_oe_ff <= 1'b1;
        end
        default:
        begin
          a_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign host_serial_data_line_out = 1'b0;
  assign host_serial_data_line_oe = a_oe_ff;
  assign host_serial_clock_line_out = b_out_ff;
  assign host_serial_clock_line_oe = b_oe_ff;
  assign pin_c_out = 1'b0;
  assign pin_c_oe = 1'b0;
  assign pin_d_out = d_out_ff;
  assign pin_d_oe = d_oe_ff;

  // ---------------------------------------------------------------
  // Receive-side demultiplex
  // ---------------------------------------------------------------
  host_pin_mux_pkg::host_rx_s rx_ff;
  logic is_2w;
  logic is_4w;
  logic is_lin;

  assign is_2w = (mode == host_pin_mux_pkg::MODE_TWO_WIRE);
  assign is_4w = (mode == host_pin_mux_pkg::MODE_FOUR_WIRE);
  assign is_lin = (mode == host_pin_mux_pkg::MODE_LIN);

  // Inactive sda, scl, ss_n and lin_rx idle high, sck, its edges and mosi low, so engines see no traffic
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
      rx_ff <= '{sda: 1'b1, scl: 1'b1, sck: 1'b0, sck_rise: 1'b0,
                 sck_fall: 1'b0, ss_n: 1'b1, mosi: 1'b0, lin_rx: 1'b1};
    else if (sys_rst)
      rx_ff <= '{sda: 1'b1, scl: 1'b1, sck: 1'b0, sck_rise: 1'b0,
                 sck_fall: 1'b0, ss_n: 1'b1, mosi: 1'b0, lin_rx: 1'b1};
    else
    begin
      rx_ff.sda <= is_2w ? sync2_ff[`PIN_A] : 1'b1;
      rx_ff.scl <= is_2w ? sync2_ff[`PIN_B] : 1'b1;
      rx_ff.sck <= is_4w && sync2_ff[`PIN_A];
      rx_ff.sck_rise <= is_4w && sync2_ff[`PIN_A] && !sck_prev_ff;
      rx_ff.sck_fall <= is_4w && !sync2_ff[`PIN_A] && sck_prev_ff;
      rx_ff.ss_n <= is_4w ? sync2_ff[`PIN_B] : 1'b1;
      rx_ff.mosi <= is_4w && sync2_ff[`PIN_C];
      rx_ff.lin_rx <= is_lin ? sync2_ff[`PIN_A] : 1'b1;
    end
  end

  assign rx = rx_ff;

  // ---------------------------------------------------------------
  // Strap capture after reset release
  // ---------------------------------------------------------------
  logic [2:0] strap_cnt_ff;
  logic addr_strap_ff;
  logic mode_strap_n_ff;

  // Wait for synchronisers to fill before sampling the straps
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      strap_cnt_ff <= 3'h0;
      addr_strap_ff <= 1'b0;
      mode_strap_n_ff <= 1'b1;
    end
    else if (sys_rst)
    begin
      strap_cnt_ff <= 3'h0;
      addr_strap_ff <= 1'b0;
      mode_strap_n_ff <= 1'b1;
    end
    else if (strap_cnt_ff != `STRAP_SETTLE_CYC)
    begin
      strap_cnt_ff <= strap_cnt_ff + 3'h1;
      if (strap_cnt_ff == `STRAP_SETTLE_CYC - 3'h1)
      begin
        addr_strap_ff <= sync2_ff[`PIN_C];
        mode_strap_n_ff <= sync2_ff[`PIN_D];
      end
    end
  end

  assign two_wire_address_strap = addr_strap_ff;
  assign two_wire_mode_strap_n = mode_strap_n_ff;

  // ---------------------------------------------------------------
  // General purpose pins
  // ---------------------------------------------------------------
  logic [2:0] gp_sync_sel;
  logic [2:0] gp_out_ff;
  logic [2:0] gp_oe_ff;
  logic [2:0] gp_in_ff;
  logic hsync_ff;
  logic vsync_ff;

  assign gp_sync_sel = {vsync_sel, hsync_sel, 1'b0};

  // Per pin: sync selection forces input so the display can drive
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_gp
      always_ff @(posedge clk or negedge master_reset_n)
      begin
        if (!master_reset_n)
        begin
          gp_out_ff[gi] <= 1'b1;
          gp_oe_ff[gi] <= 1'b0;
          gp_in_ff[gi] <= 1'b1;
        end
        else if (sys_rst)
        begin
          gp_out_ff[gi] <= 1'b1;
          gp_oe_ff[gi] <= 1'b0;
          gp_in_ff[gi] <= 1'b1;
        end
        else
        begin
          gp_out_ff[gi] <= gp_out[gi];
          gp_oe_ff[gi] <= gp_dir[gi] && !gp_sync_sel[gi];
          gp_in_ff[gi] <= sync2_ff[`PIN_GP0+gi];
        end
      end
    end
  endgenerate

  // Sync outputs hold low when not selected
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      hsync_ff <= 1'b0;
      vsync_ff <= 1'b0;
    end
    else if (sys_rst)
    begin
      hsync_ff <= 1'b0;
      vsync_ff <= 1'b0;
    end
    else
    begin
      hsync_ff <= hsync_sel && sync2_ff[`PIN_GP0+`GP_HSYNC_IDX];
      vsync_ff <= vsync_sel && sync2_ff[`PIN_GP0+`GP_VSYNC_IDX];
    end
  end

  assign gp_pin_out = gp_out_ff;
  assign gp_pin_oe = gp_oe_ff;
  assign gp_in = gp_in_ff;
  assign hsync = hsync_ff;
  assign external_frame_sync = vsync_ff;

endmodule
`default_nettype wire

// File: sim/host_port_pin_mux_irq_props.sv
// Checker for the host pin mux and report interrupt.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_mux_irq_props #(
  parameter int CNT_W = 4
) (
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_reset_n,
  // Core side
  input wire host_pin_mux_pkg::host_mode_e mode,
  input wire logic lin_en_sel,
  input wire logic hsync_sel,
  input wire logic vsync_sel,
  input wire logic report_push,
  input wire logic report_consumed,
  input wire host_pin_mux_pkg::host_tx_s tx,
  input wire host_pin_mux_pkg::host_rx_s rx,
  input wire logic [CNT_W-1:0] pending_count,
  input wire logic [2:0] gp_dir,
  // Pin drive
  input wire logic [2:0] gp_pin_oe,
  input wire logic report_pending_irq_n_oe,
  input wire logic host_serial_data_line_oe,
  input wire logic host_serial_clock_line_oe,
  input wire logic host_serial_clock_line_out,
  input wire logic pin_d_oe
);
  // ----------------------------------
  // Properties
  // ----------------------------------
  localparam logic [CNT_W-1:0] FULL = '1;
  localparam host_pin_mux_pkg::host_mode_e LIN = host_pin_mux_pkg::MODE_LIN;
  localparam host_pin_mux_pkg::host_mode_e FOUR = host_pin_mux_pkg::MODE_FOUR_WIRE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !master_reset_n);
  a_push_count: assert property (
    report_push && !report_consumed && pending_count != FULL
    |=> pending_count == $past(pending_count) + 1'b1) else $error("push lost");
  a_pop_count: assert property (
    report_consumed && !report_push && pending_count != '0
    |=> pending_count == $past(pending_count) - 1'b1) else $error("read lost");
  a_irq_level: assert property (
    !mode[1] && !$past(mode[1])
    |-> report_pending_irq_n_oe == (pending_count != '0)) else $error("irq level");
  a_lin_enable: assert property (
    mode == LIN && lin_en_sel
    |=> report_pending_irq_n_oe == !$past(tx.lin_transceiver_enable)) else $error("lin en");
  a_pin_a_input: assert property (
    mode == FOUR || mode == LIN |=> !host_serial_data_line_oe) else $error("pin a driven");
  a_sda_drive: assert property (
    mode == host_pin_mux_pkg::MODE_TWO_WIRE
    |=> host_serial_data_line_oe == $past(tx.sda_low)) else $error("sda drive");
  a_pin_b_input: assert property (
    !mode[1] |=> !host_serial_clock_line_oe) else $error("pin b driven");
  a_lin_tx: assert property (
    mode == LIN |=> host_serial_clock_line_oe
    && host_serial_clock_line_out == $past(tx.lin_tx)) else $error("lin tx");
  a_miso_select: assert property (
    mode == FOUR && $past(mode) == FOUR |-> pin_d_oe == !rx.ss_n) else $error("miso oe");
  a_gp_drive: assert property (
    1'b1 |=> gp_pin_oe == ($past(gp_dir) & ~{$past(vsync_sel), $past(hsync_sel), 1'b0}))
    else $error("gp oe");
  a_async_clear: assert property (disable iff (sys_rst)
    !master_reset_n |-> pending_count == '0 && !report_pending_irq_n_oe) else $error("rst");
  c_full: cover property (report_push && pending_count == FULL);
  c_sck_rise: cover property (rx.sck_rise);
  c_lin_en: cover property (mode == LIN && lin_en_sel);
endmodule
`default_nettype wire

// File: sim/host_proc_model.sv
// Host processor on the far side of the shared host pins.
// Assumes the bench feeds the resolved wires back to the device.
`timescale 1ns/1ps
`default_nettype none
module host_proc_model (
  // Host commands
  input wire logic sck_run,
  input wire logic ss_n,
  // Device drive
  input wire logic a_oe,
  input wire logic b_oe,
  input wire logic b_out,
  input wire logic irq_oe,
  // Resolved wires
  output logic a_in,
  output logic b_in,
  output logic irq_in,
  output logic irq_seen,
  output logic sck
);
  // ----------------------------------
  // Link clock and pin levels
  // ----------------------------------
  // Clock stands still between frames, 160 ns inside
  initial sck = 1'b1;
  always #80 if (sck_run) sck = !sck;
  // Host sck, host ss_n and the interrupt pull-up win unless the device drives
  assign a_in = a_oe ? 1'b0 : sck;
  assign b_in = b_oe ? b_out : ss_n;
  assign irq_in = !irq_oe;
  // Level sensing, so queued reports are never missed
  assign irq_seen = !irq_in;
endmodule
`default_nettype wire

// File: sim/tb_host_port_pin_mux_irq.sv
// Self-checking bench for the host pin mux and report interrupt.
// Assumes the host model resolves pins A, B and the interrupt.
`timescale 1ns/1ps
`default_nettype none
module tb_host_port_pin_mux_irq;
  localparam int CNT_W = 4;
  logic clk = 1'b0, sys_rst = 1'b1, master_reset_n = 1'b1;
  host_pin_mux_pkg::host_mode_e mode = host_pin_mux_pkg::MODE_TWO_WIRE;
  logic lin_en_sel = 1'b0, hsync_sel = 1'b0, vsync_sel = 1'b0;
  logic report_push = 1'b0, report_consumed = 1'b0;
  host_pin_mux_pkg::host_tx_s tx = '0;
  host_pin_mux_pkg::host_rx_s rx;
  logic [CNT_W-1:0] pending_count;
  logic two_wire_address_strap, two_wire_mode_strap_n, hsync, external_frame_sync;
  logic [2:0] gp_out = 3'h0, gp_dir = 3'h0, gp_drv = 3'h7, gp_in, gp_pin_in, gp_pin_out;
  logic [2:0] gp_pin_oe, oe_x;
  logic report_pending_irq_n_in, report_pending_irq_n_out, report_pending_irq_n_oe;
  logic host_serial_data_line_in, host_serial_data_line_out, host_serial_data_line_oe;
  logic host_serial_clock_line_in, host_serial_clock_line_out, host_serial_clock_line_oe;
  logic pin_c_in = 1'b1, pin_c_out, pin_c_oe, pin_d_in, pin_d_out, pin_d_oe, strap_d = 1'b1;
  logic sck_run = 1'b0, ss_n = 1'b1, irq_seen, sck;
  int miscompares = 0, num_checks = 0, rises = 0, falls = 0;
  int exp_q[$];
  // ----------------------------------
  // Wiring, clock and instances
  // ----------------------------------
  // Wires resolved from every party's enable
  assign gp_pin_in = (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & gp_drv);
  assign pin_d_in = pin_d_oe ? pin_d_out : strap_d;
  always #5 clk = ~clk;
  always @(posedge clk) if (rx.sck_rise === 1'b1) rises++;
  always @(posedge clk) if (rx.sck_fall === 1'b1) falls++;
  host_port_pin_mux_irq #(.CNT_W(CNT_W)) u_host_port_pin_mux_irq (.clk, .sys_rst,
    .master_reset_n, .mode, .lin_en_sel, .hsync_sel, .vsync_sel, .report_push,
    .report_consumed, .tx, .rx, .pending_count, .two_wire_address_strap,
    .two_wire_mode_strap_n, .gp_out, .gp_dir, .gp_in, .hsync, .external_frame_sync,
    .report_pending_irq_n_in, .report_pending_irq_n_out, .report_pending_irq_n_oe,
    .host_serial_data_line_in, .host_serial_data_line_out, .host_serial_data_line_oe,
    .host_serial_clock_line_in, .host_serial_clock_line_out, .host_serial_clock_line_oe,
    .pin_c_in, .pin_c_out, .pin_c_oe, .pin_d_in, .pin_d_out, .pin_d_oe, .gp_pin_in,
    .gp_pin_out, .gp_pin_oe);
  host_proc_model u_host_proc_model (.sck_run, .ss_n, .a_oe(host_serial_data_line_oe),
    .b_oe(host_serial_clock_line_oe), .b_out(host_serial_clock_line_out),
    .irq_oe(report_pending_irq_n_oe), .a_in(host_serial_data_line_in),
    .b_in(host_serial_clock_line_in), .irq_in(report_pending_irq_n_in), .irq_seen, .sck);
  // ----------------------------------
  // Tasks
  // ----------------------------------
  // Inputs set after step move 1 ns after the edge
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string name, logic [7:0] ex, logic [7:0] got);
    num_checks++;
    if (got !== ex)
    begin
      miscompares++;
      $display("MISMATCH %s exp %0h got %0h", name, ex, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------
  // Tests
  // ----------------------------------
  // Hang guard, far beyond the roughly 350 cycles needed
  initial
  begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h0D6BF95B));
    pin_c_in = 1'($urandom);
    strap_d = 1'($urandom);
    step(2);
    sys_rst = 1'b0;
    step(5);
    chk("addr strap", pin_c_in, two_wire_address_strap);
    chk("mode strap", strap_d, two_wire_mode_strap_n);
    $display("test straps done");
    // Fill past saturation, drain past empty, then random traffic
    for (int i = 0; i < 120; i++)
    begin
      report_push = i < 18 || (i >= 38 && 1'($urandom));
      report_consumed = (i >= 18 && i < 38) || (i >= 38 && 1'($urandom));
      step();
      if (report_push && !report_consumed && exp_q.size() < 2**CNT_W - 1) exp_q.push_back(i);
      if (report_consumed && !report_push && exp_q.size() > 0) void'(exp_q.pop_front());
      chk("count", exp_q.size(), pending_count);
      chk("irq", exp_q.size() != 0, irq_seen);
    end
    report_consumed = 1'b0;
    report_push = 1'b1;
    step(3);
    report_push = 1'b0;
    #2 master_reset_n = 1'b0;
    #1 chk("async clear", 0, pending_count);
    step(2);
    master_reset_n = 1'b1;
    step(5);
    $display("test queue done");
    mode = host_pin_mux_pkg::MODE_FOUR_WIRE;
    ss_n = 1'b0;
    step(4);
    chk("ss_n", 0, rx.ss_n);
    chk("miso oe", 1, pin_d_oe);
    chk("mosi", pin_c_in, rx.mosi);
    sck_run = 1'b1;
    repeat (8) @(posedge sck);
    sck_run = 1'b0;
    ss_n = 1'b1;
    step(5);
    chk("sck rises", 8, rises);
    chk("sck falls", 8, falls);
    chk("miso off", 0, pin_d_oe);
    $display("test four wire done");
    lin_en_sel = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      mode = i[0] ? host_pin_mux_pkg::MODE_LIN : host_pin_mux_pkg::MODE_TWO_WIRE;
      tx = host_pin_mux_pkg::host_tx_s'(4'($urandom));
      step(4);
      if (i[0])
      begin
        chk("lin tx", tx.lin_tx, host_serial_clock_line_in);
        chk("lin en", !tx.lin_transceiver_enable, irq_seen);
        chk("lin rx", 1, rx.lin_rx);
      end
      else
      begin
        chk("sda", !tx.sda_low, host_serial_data_line_in);
        chk("sda rx", !tx.sda_low, rx.sda);
        chk("scl rx", 1, rx.scl);
      end
    end
    mode = host_pin_mux_pkg::MODE_NONE;
    step(2);
    chk("none oe", 0, {host_serial_data_line_oe, host_serial_clock_line_oe, pin_d_oe});
    chk("none rx", 8'hF, {rx.sda, rx.scl, rx.ss_n, rx.lin_rx});
    $display("test modes done");
    for (int i = 0; i < 8; i++)
    begin
      {hsync_sel, vsync_sel, gp_dir, gp_out, gp_drv} = 11'($urandom);
      step(5);
      oe_x = gp_dir & ~{vsync_sel, hsync_sel, 1'b0};
      chk("gp in", (oe_x & gp_out) | (~oe_x & gp_drv), gp_in);
      chk("hsync", hsync_sel & gp_drv[1], hsync);
      chk("fsync", vsync_sel & gp_drv[2], external_frame_sync);
    end
    $display("test gp done");
    stop_test();
  end
endmodule
bind host_port_pin_mux_irq host_port_pin_mux_irq_props #(.CNT_W(CNT_W)) u_props (.clk,
  .sys_rst, .master_reset_n, .mode, .lin_en_sel, .hsync_sel, .vsync_sel, .report_push,
  .report_consumed, .tx, .rx, .pending_count, .gp_dir, .gp_pin_oe,
  .report_pending_irq_n_oe, .host_serial_data_line_oe, .host_serial_clock_line_oe,
  .host_serial_clock_line_out, .pin_d_oe);
`default_nettype wire
